// file: logic/watchdog_timer_with_reset.sv
// Watchdog top: register port, control flags, reset pulse and interrupt
`timescale 1ns/100ps
module watchdog_timer_with_reset #(
    parameter int unsigned INTERVAL0 = 131072,
    parameter int unsigned INTERVAL1 = 1048576,
    parameter int unsigned INTERVAL2 = 8388608,
    parameter int unsigned INTERVAL3 = 67108864
) (
    // Clock and power-on reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port
    input wire logic [wdt_pkg::ADDR_W-1:0] regAddr,
    input wire logic [wdt_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [wdt_pkg::DATA_W-1:0] regRdata,
    // System side
    output logic sysRstOut,
    output logic irq
);
    import wdt_pkg::*;
    localparam int HW = $clog2(RST_HOLD_CLKS + 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(RST_HOLD_CLKS - 1);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic tof_q;
    logic tof_d;
    logic cause_q;
    logic cause_d;
    logic rsten_q;
    logic run_q;
    logic [1:0] sel_q;
    logic [1:0] sel_d;
    logic [5:0] clkRest_q;
    logic extIe_q;
    logic globIe_q;
    logic [IST_W-1:0] istat_q;
    logic [IST_W-1:0] istat_d;
    logic [IST_W-1:0] imask_q;
    logic rstAct_q;
    logic [HW-1:0] rstCnt_q;
    logic [DATA_W-1:0] rdata_q;
    logic irq_q;
    logic irq_d;

    wdt_if link();

    ////////////////////////////////////////////////////////////////////////
    // Submodules
    wdt_counter #(
        .INTERVAL0(INTERVAL0),
        .INTERVAL1(INTERVAL1),
        .INTERVAL2(INTERVAL2),
        .INTERVAL3(INTERVAL3)
    ) u_counter (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .bus(link.cnt)
    );

    wdt_unlock u_unlock (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .bus(link.lock)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    wire wrWd;
    wire wrCk;
    wire wrKey;
    wire wrIe;
    wire wrIs;
    wire wrIm;
    wire protOk;
    wire restartReq;
    wire fireRst;
    wire [IST_W-1:0] istClr;
    wire [IST_W-1:0] istSet;

    assign wrWd = regWrite & (regAddr == OFS_WDCTL);
    assign wrCk = regWrite & (regAddr == OFS_CLKCTL);
    assign wrKey = regWrite & (regAddr == OFS_KEY);
    assign wrIe = regWrite & (regAddr == OFS_IRQEN);
    assign wrIs = regWrite & (regAddr == OFS_ISTAT);
    assign wrIm = regWrite & (regAddr == OFS_IMASK);

    // Protected write only inside the unlock window
    assign protOk = wrWd & link.unlocked;
    assign restartReq = protOk & regWdata[RESTART_BIT];

    // Grace window ran out with reset enabled
    assign fireRst = link.expire & rsten_q & ~rstAct_q;

    // Links to the counter and unlock logic
    assign link.restart = restartReq | fireRst;
    assign link.run = run_q;
    assign link.sel = sel_q;
    assign link.keyWr = wrKey;
    assign link.keyData = regWdata;
    assign link.consume = protOk;

    ////////////////////////////////////////////////////////////////////////
    // Next values of flags

    // Time-out flag: reset clears, new time-out beats software clear
    always_comb begin
        tof_d = tof_q;
        if (fireRst) begin
            tof_d = 1'b0;
        end else if (link.timeout) begin
            tof_d = 1'b1;
        end else if (protOk) begin
            tof_d = regWdata[TOF_BIT];
        end
    end

    // Cause flag: set on watchdog reset, cleared by writing zero
    always_comb begin
        cause_d = cause_q;
        if (fireRst) begin
            cause_d = 1'b1;
        end else if (wrWd && !regWdata[CAUSE_BIT]) begin
            cause_d = 1'b0;
        end
    end

    // Interval select returns to shortest on watchdog reset
    always_comb begin
        sel_d = sel_q;
        if (fireRst) begin
            sel_d = SEL_DEFAULT;
        end else if (wrCk) begin
            sel_d = {regWdata[SEL_HI_BIT], regWdata[SEL_LO_BIT]};
        end
    end

    // Sticky events, write one to clear, set wins
    assign istSet = {fireRst, link.timeout};
    assign istClr = wrIs ? regWdata[IST_W-1:0] : '0;
    assign istat_d = (istat_q & ~istClr) | istSet;

    // Interrupt request: time-out path needs both enables
    assign irq_d = (istat_q[IST_TO_BIT] & imask_q[IST_TO_BIT] & extIe_q & globIe_q)
                 | (istat_q[IST_RST_BIT] & imask_q[IST_RST_BIT] & globIe_q);

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tof_q <= 1'b0;
            cause_q <= 1'b0;
            rsten_q <= 1'b0;
            run_q <= 1'b0;
            sel_q <= SEL_DEFAULT;
            clkRest_q <= CLKREST_RESET;
        end else begin
            tof_q <= tof_d;
            cause_q <= cause_d;
            sel_q <= sel_d;
            if (protOk) begin
                rsten_q <= regWdata[RSTEN_BIT];
            end
            if (restartReq) begin
                run_q <= 1'b1;
            end
            if (wrCk) begin
                clkRest_q <= regWdata[5:0];
            end
        end
    end

    // Interrupt enable, status and mask registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            extIe_q <= 1'b0;
            globIe_q <= 1'b0;
            istat_q <= '0;
            imask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            if (wrIe) begin
                extIe_q <= regWdata[EXT_IE_BIT];
                globIe_q <= regWdata[GLOB_IE_BIT];
            end
            if (wrIm) begin
                imask_q <= regWdata[IST_W-1:0];
            end
            istat_q <= istat_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System reset pulse, two machine cycles long
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstAct_q <= 1'b0;
            rstCnt_q <= '0;
        end else if (fireRst) begin
            rstAct_q <= 1'b1;
            rstCnt_q <= HOLD_LAST;
        end else if (rstAct_q) begin
            if (rstCnt_q == '0) begin
                rstAct_q <= 1'b0;
            end else begin
                rstCnt_q <= rstCnt_q - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path
    wire [DATA_W-1:0] wdCtlRd;
    wire [DATA_W-1:0] clkCtlRd;
    wire [DATA_W-1:0] irqEnRd;
    wire [DATA_W-1:0] istRd;
    wire [DATA_W-1:0] imRd;
    wire [DATA_W-1:0] rdMux;

    // Restart bit always reads back zero
    assign wdCtlRd = DATA_W'({tof_q, cause_q, rsten_q, 1'b0});
    assign clkCtlRd = {sel_q, clkRest_q};
    assign irqEnRd = DATA_W'({globIe_q, 2'h0, extIe_q, 4'h0});
    assign istRd = DATA_W'(istat_q);
    assign imRd = DATA_W'(imask_q);
    assign rdMux = (regAddr == OFS_WDCTL) ? wdCtlRd :
                   (regAddr == OFS_CLKCTL) ? clkCtlRd :
                   (regAddr == OFS_IRQEN) ? irqEnRd :
                   (regAddr == OFS_ISTAT) ? istRd :
                   (regAddr == OFS_IMASK) ? imRd : '0;

    // Read data stands one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= regRead ? rdMux : '0;
        end
    end

    // Outputs straight from flops
    assign regRdata = rdata_q;
    assign sysRstOut = rstAct_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Checking helpers
    logic [9:0] sinceTo_q;
    logic [HW:0] holdLen_q;
    wire rstReq;
    wire toGate;

    assign rstReq = istat_q[IST_RST_BIT] & imask_q[IST_RST_BIT];
    assign toGate = extIe_q & globIe_q;

    // Cycles since the last time-out pulse, and length of reset pulse
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sinceTo_q <= '0;
            holdLen_q <= '0;
        end else begin
            if (link.timeout) begin
                sinceTo_q <= 10'h001;
            end else if (sinceTo_q != 10'h3FF) begin
                sinceTo_q <= sinceTo_q + 1'b1;
            end
            holdLen_q <= sysRstOut ? holdLen_q + 1'b1 : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_fire;
        fireRst;
    endsequence

    sequence s_hold_start;
        ##1 (sysRstOut && cause_q);
    endsequence

    property p_interval_default;
        s_fire |=> (sel_q == SEL_DEFAULT);
    endproperty
    a_interval_default: assert property (p_interval_default) else $error("interval not back to default");

    property p_tof_set;
        link.timeout |=> tof_q;
    endproperty
    a_tof_set: assert property (p_tof_set) else $error("time-out flag not set");

    property p_irq_gate;
        (irq_q && !$past(rstReq)) |-> $past(toGate);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt without both enables");

    property p_tof_clear;
        (protOk && !regWdata[TOF_BIT] && !link.timeout) |=> !tof_q;
    endproperty
    a_tof_clear: assert property (p_tof_clear) else $error("time-out flag not cleared");

    property p_grace;
        link.expire |-> (sinceTo_q == 10'(GRACE_CLKS));
    endproperty
    a_grace: assert property (p_grace) else $error("grace window length wrong");

    property p_rst_start;
        s_fire |-> s_hold_start;
    endproperty
    a_rst_start: assert property (p_rst_start) else $error("reset or cause flag missing");

    property p_rst_len;
        $fell(sysRstOut) |-> (holdLen_q == (HW + 1)'(RST_HOLD_CLKS));
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");

    property p_cause_keep;
        (!rsten_q && !wrWd) |=> $stable(cause_q);
    endproperty
    a_cause_keep: assert property (p_cause_keep) else $error("cause flag moved while disabled");

    property p_no_reset_off;
        (link.expire && !rsten_q) |=> !$rose(sysRstOut);
    endproperty
    a_no_reset_off: assert property (p_no_reset_off) else $error("reset while disabled");

    property p_restart;
        restartReq |=> (!link.timeout && !link.expire && !link.inGrace) [*8];
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear counter");

    property p_run_kept;
        s_fire |=> run_q;
    endproperty
    a_run_kept: assert property (p_run_kept) else $error("watchdog reset disabled counter");

    property p_protect;
        (wrWd && !link.unlocked) |=> $stable(rsten_q);
    endproperty
    a_protect: assert property (p_protect) else $error("unprotected write took effect");
endmodule : watchdog_timer_with_reset

// file: common/wdt_pkg.sv
// Watchdog register map, field layout and timing constants
//
// Contract
// - Interval field bits 7:6 select time-out length
// - Any reset returns interval to shortest
// - Every completed interval sets time-out flag
// - Flag interrupts only with both enables set
// - Software write or any reset clears flag
// - Missing restart 512 clocks later issues reset
// - Reset lasts two machine cycles, sets cause
// - Cause flag set on reset, software clears
// - Reset enable gates only the reset path
// - Restart bit clears counter, then self-clears
// - Power-on or power-fail reset disables watchdog
// - Watchdog reset restarts counter, keeps it enabled
// - Interrupt and reset paths act independently
// - Protected bits need AAH then 55H first
package wdt_pkg;
    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [7:0] OFS_WDCTL = 8'h00;
    localparam logic [7:0] OFS_CLKCTL = 8'h04;
    localparam logic [7:0] OFS_KEY = 8'h08;
    localparam logic [7:0] OFS_IRQEN = 8'h0C;
    localparam logic [7:0] OFS_ISTAT = 8'h10;
    localparam logic [7:0] OFS_IMASK = 8'h14;
    // Watchdog control fields
    localparam int TOF_BIT = 3;
    localparam int CAUSE_BIT = 2;
    localparam int RSTEN_BIT = 1;
    localparam int RESTART_BIT = 0;
    // Clock control fields
    localparam int SEL_HI_BIT = 7;
    localparam int SEL_LO_BIT = 6;
    localparam logic [1:0] SEL_DEFAULT = 2'h0;
    localparam logic [5:0] CLKREST_RESET = 6'h00;
    // Interrupt enable fields
    localparam int EXT_IE_BIT = 4;
    localparam int GLOB_IE_BIT = 7;
    // Interrupt status and mask fields
    localparam int IST_W = 2;
    localparam int IST_TO_BIT = 0;
    localparam int IST_RST_BIT = 1;
    // Unlock keys and window
    localparam logic [7:0] KEY_FIRST = 8'hAA;
    localparam logic [7:0] KEY_SECOND = 8'h55;
    localparam int KEY_WINDOW = 3;
    // Counter timing
    localparam int CNT_W = 26;
    localparam int GRACE_CLKS = 512;
    localparam int MC_CLKS = 12;
    localparam int RST_HOLD_CLKS = 2 * MC_CLKS;
endpackage : wdt_pkg

// file: common/wdt_if.sv
// Internal link between watchdog control, counter and unlock logic
`timescale 1ns/100ps
interface wdt_if;
    logic restart;
    logic run;
    logic [1:0] sel;
    logic timeout;
    logic expire;
    logic inGrace;
    logic keyWr;
    logic [7:0] keyData;
    logic consume;
    logic unlocked;
    // Control side
    modport ctrl(output restart, run, sel, keyWr, keyData, consume,
                 input timeout, expire, inGrace, unlocked);
    // Divider chain side
    modport cnt(input restart, run, sel, output timeout, expire, inGrace);
    // Key sequence side
    modport lock(input keyWr, keyData, consume, output unlocked);
endinterface : wdt_if

// file: logic/wdt_counter.sv
// Watchdog divider chain and post time-out grace window
`timescale 1ns/100ps
module wdt_counter #(
    parameter int unsigned INTERVAL0 = 131072,
    parameter int unsigned INTERVAL1 = 1048576,
    parameter int unsigned INTERVAL2 = 8388608,
    parameter int unsigned INTERVAL3 = 67108864
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Control link
    wdt_if.cnt bus
);
    import wdt_pkg::*;
    localparam int GW = $clog2(GRACE_CLKS);
    localparam logic [GW-1:0] GRACE_LAST = GW'(GRACE_CLKS - 1);

    logic [CNT_W-1:0] divCnt_q;
    logic [GW-1:0] grace_q;
    logic inGrace_q;
    logic timeout_q;
    logic expire_q;
    wire [CNT_W-1:0] limit;
    wire hit;
    wire graceEnd;

    // Terminal count for the selected interval
    assign limit = (bus.sel == 2'h0) ? CNT_W'(INTERVAL0 - 1) :
                   (bus.sel == 2'h1) ? CNT_W'(INTERVAL1 - 1) :
                   (bus.sel == 2'h2) ? CNT_W'(INTERVAL2 - 1) : CNT_W'(INTERVAL3 - 1);
    assign hit = bus.run & (divCnt_q == limit);
    assign graceEnd = inGrace_q & (grace_q == GRACE_LAST);
    assign bus.timeout = timeout_q;
    assign bus.expire = expire_q;
    assign bus.inGrace = inGrace_q;

    // Divider, grace window and event pulses
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            divCnt_q <= '0;
            grace_q <= '0;
            inGrace_q <= 1'b0;
            timeout_q <= 1'b0;
            expire_q <= 1'b0;
        end else if (bus.restart) begin
            divCnt_q <= '0;
            grace_q <= '0;
            inGrace_q <= 1'b0;
            timeout_q <= 1'b0;
            expire_q <= 1'b0;
        end else begin
            divCnt_q <= hit ? '0 : (bus.run ? divCnt_q + 1'b1 : divCnt_q);
            timeout_q <= hit;
            inGrace_q <= hit | (inGrace_q & ~graceEnd);
            grace_q <= (hit | ~inGrace_q) ? '0 : grace_q + 1'b1;
            expire_q <= graceEnd & ~hit;
        end
    end
endmodule : wdt_counter

// file: logic/wdt_unlock.sv
// Timed-access key sequence guarding protected control bits
`timescale 1ns/100ps
module wdt_unlock (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Control link
    wdt_if.lock bus
);
    import wdt_pkg::*;
    localparam int WW = $clog2(KEY_WINDOW + 1);

    typedef enum logic [2:0] {
        LK_IDLE = 3'b001,
        LK_ARMED = 3'b010,
        LK_OPEN = 3'b100
    } lock_state_t;

    lock_state_t state_q;
    logic [WW-1:0] win_q;
    wire isFirst;
    wire isSecond;

    // Key byte decode
    assign isFirst = bus.keyWr & (bus.keyData == KEY_FIRST);
    assign isSecond = bus.keyWr & (bus.keyData == KEY_SECOND);
    assign bus.unlocked = (state_q == LK_OPEN);

    // Key sequence and expiring window
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= LK_IDLE;
            win_q <= '0;
        end else begin
            case (state_q)
                LK_IDLE: begin
                    if (isFirst) begin
                        state_q <= LK_ARMED;
                    end
                end
                LK_ARMED: begin
                    if (isSecond) begin
                        state_q <= LK_OPEN;
                        win_q <= WW'(KEY_WINDOW - 1);
                    end else if (bus.keyWr && !isFirst) begin
                        state_q <= LK_IDLE;
                    end
                end
                LK_OPEN: begin
                    if (bus.consume || bus.keyWr || win_q == '0) begin
                        state_q <= LK_IDLE;
                    end else begin
                        win_q <= win_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= LK_IDLE;
                end
            endcase
        end
    end
endmodule : wdt_unlock

// file: verif/tb.sv
// Self-checking bench for the watchdog timer with reset
`timescale 1ns/100ps
module tb;
    import wdt_pkg::*;
    // Shortened intervals, all above the grace window
    localparam int unsigned IVS [4] = '{640, 768, 896, 1024};
    ////////////////////////////////////////////////////////////////////////
    // Clock, reset and design ports
    logic sys_clk;
    logic rstn;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata;
    logic regWrite;
    logic regRead;
    logic [DATA_W-1:0] regRdata;
    logic sysRstOut;
    logic irq;
    int fails;
    int samples_checked;
    int cyc = 0;
    int e;
    int r1;
    logic [31:0] lfsrQ;
    logic [7:0] rdv;
    logic [7:0] lowBits;

    watchdog_timer_with_reset #(.INTERVAL0(IVS[0]), .INTERVAL1(IVS[1]), .INTERVAL2(IVS[2]),
        .INTERVAL3(IVS[3])) watchdog_timer_with_reset_i (.sys_clk(sys_clk), .rstn(rstn),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .sysRstOut(sysRstOut), .irq(irq));

    // Free-running clock and a cycle count stable at rising edges
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        cyc <= cyc + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    // Expectation helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic exp_irq(input logic [7:0] en, input logic [7:0] mask, input logic [7:0] st);
        return en[GLOB_IE_BIT] & ((st[IST_TO_BIT] & mask[IST_TO_BIT] & en[EXT_IE_BIT]) |
            (st[IST_RST_BIT] & mask[IST_RST_BIT]));
    endfunction : exp_irq
    ////////////////////////////////////////////////////////////////////////
    // Bus tasks and comparison
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %0h expected %0h", $time, msg, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    task automatic prot(input logic [7:0] d);
        wr(OFS_KEY, KEY_FIRST);
        wr(OFS_KEY, KEY_SECOND);
        wr(OFS_WDCTL, d);
    endtask : prot
    task automatic wait_to(input int t);
        while (cyc < t) @(posedge sys_clk);
    endtask : wait_to
    task automatic wait_rst(input logic lvl, input int limit);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (sysRstOut !== lvl && n < limit);
    endtask : wait_rst
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        #300000;
        fails++;
        test_done();
    end
    // Main sequence
    initial begin
        logic [7:0] addrs [7];
        addrs = '{OFS_WDCTL, OFS_CLKCTL, OFS_KEY, OFS_IRQEN, OFS_ISTAT, OFS_IMASK, 8'h20};
        fails = 0;
        samples_checked = 0;
        lfsrQ = 32'h0000_4e63;
        rstn = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        // Reset values, key and unmapped reads give zero
        foreach (addrs[i]) begin
            rd(addrs[i], rdv);
            check(rdv, 8'h00, "reset value");
        end
        $display("test reset_values done");
        // Locked, late-unlocked writes ignored; stays disabled after power-on
        wr(OFS_WDCTL, 8'h03);
        wr(OFS_KEY, KEY_FIRST);
        wr(OFS_KEY, KEY_SECOND);
        repeat (5) @(posedge sys_clk);
        wr(OFS_WDCTL, 8'h03);
        e = cyc;
        wait_to(e + IVS[0] + 600);
        rd(OFS_WDCTL, rdv);
        check(rdv, 8'h00, "protected write took effect");
        check(sysRstOut, 1'b0, "reset while disabled");
        $display("test lock done");
        // Each interval, reset path off, flag repeats every interval
        for (int s = 0; s < 4; s++) begin
            lfsrQ = lfsr_next(lfsrQ);
            lowBits = {2'b00, lfsrQ[5:0]};
            wr(OFS_CLKCTL, {s[1:0], lowBits[5:0]});
            rd(OFS_CLKCTL, rdv);
            check(rdv, {s[1:0], lowBits[5:0]}, "clock control readback");
            prot(8'h01);
            e = cyc;
            wait_to(e + IVS[s] - 6);
            rd(OFS_WDCTL, rdv);
            check(rdv[TOF_BIT], 1'b0, "early time-out");
            wait_to(e + IVS[s] + 6);
            rd(OFS_WDCTL, rdv);
            check(rdv, 8'h08, "time-out flag");
            wait_to(e + IVS[s] + 600);
            check(sysRstOut, 1'b0, "reset with enable off");
            prot(8'h00);
            rd(OFS_WDCTL, rdv);
            check(rdv, 8'h00, "flag clear");
            wait_to(e + 2 * IVS[s] + 6);
            rd(OFS_WDCTL, rdv);
            check(rdv[TOF_BIT], 1'b1, "second time-out");
        end
        $display("test intervals done");
        // Interrupt enable combinations against the time-out event
        wr(OFS_IMASK, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_IRQEN, {i[1], 2'b00, i[0], 4'h0});
            repeat (2) @(posedge sys_clk);
            check(irq, exp_irq({i[1], 2'b00, i[0], 4'h0}, 8'h01, 8'h01), "irq enables");
        end
        wr(OFS_IMASK, 8'h00);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0, "irq masked");
        wr(OFS_IMASK, 8'h01);
        wr(OFS_ISTAT, 8'h01);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0, "irq after status clear");
        wr(OFS_IRQEN, 8'h00);
        $display("test interrupt done");
        // Restart inside grace window cancels, then reset timing and hold
        wr(OFS_CLKCTL, {2'b01, lowBits[5:0]});
        prot(8'h03);
        e = cyc;
        wait_to(e + IVS[1] + 300);
        lfsrQ = lfsr_next(lfsrQ);
        repeat (lfsrQ[7:0] % 150) @(posedge sys_clk);
        check(sysRstOut, 1'b0, "reset before window end");
        prot(8'h03);
        e = cyc;
        wait_rst(1'b1, IVS[1] + 700);
        check(cyc - e, IVS[1] + 513, "reset delay");
        r1 = cyc;
        wait_rst(1'b0, 100);
        check(cyc - r1, RST_HOLD_CLKS, "reset length");
        rd(OFS_WDCTL, rdv);
        check(rdv, 8'h06, "control after watchdog reset");
        rd(OFS_ISTAT, rdv);
        check(rdv[IST_RST_BIT], 1'b1, "reset event status");
        // Reset event alone raises the interrupt with only the global enable
        wr(OFS_IMASK, 8'h02);
        wr(OFS_IRQEN, 8'h80);
        repeat (2) @(posedge sys_clk);
        check(irq, exp_irq(8'h80, 8'h02, 8'h03), "irq reset path");
        wr(OFS_ISTAT, 8'h02);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0, "irq after reset event clear");
        wr(OFS_IMASK, 8'h00);
        wr(OFS_IRQEN, 8'h00);
        rd(OFS_CLKCTL, rdv);
        check(rdv[7:6], 2'b00, "interval after watchdog reset");
        wait_rst(1'b1, IVS[0] + 700);
        check(cyc - r1, IVS[0] + 513, "restart by own reset");
        wait_rst(1'b0, 100);
        wr(OFS_WDCTL, 8'h00);
        rd(OFS_WDCTL, rdv);
        check(rdv, 8'h02, "cause clear by software");
        $display("test watchdog_reset done");
        wr(OFS_CLKCTL, 8'hC5);
        // Power-on reset in mid-run disables and restores defaults
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(OFS_CLKCTL, rdv);
        check(rdv, 8'h00, "clock control after reset");
        e = cyc;
        wait_to(e + IVS[0] + 600);
        rd(OFS_WDCTL, rdv);
        check(rdv, 8'h00, "control after power reset");
        check(sysRstOut, 1'b0, "reset after power reset");
        $display("test power_reset done");
        test_done();
    end
endmodule : tb
